// ===== design/cpu_opcode_addressing_unit.v
`include "opcode_addr_map.vh"

module cpu_opcode_addressing_unit (
    input wire clk_sys,
    input wire rst_n,
    output wire [15:0] mem_addr,
    output wire mem_rd,
    input wire [7:0] mem_rdata,
    input wire [7:0] index_reg,
    input wire flag_c,
    input wire flag_z,
    input wire flag_n,
    input wire flag_h,
    input wire flag_i,
    input wire irq_line,
    input wire pc_load,
    input wire [15:0] pc_load_value,
    output wire instr_valid,
    output wire [7:0] opcode,
    output wire [2:0] instr_group,
    output wire [3:0] addr_mode,
    output wire [1:0] instr_len,
    output wire [15:0] eff_addr,
    output wire [7:0] operand,
    output wire [2:0] bit_num,
    output wire branch_taken,
    output wire bit_carry,
    output wire write_back,
    output wire uses_register,
    output wire [15:0] pc
);

    reg [2:0] state_r;
    reg [15:0] pc_r;
    reg [7:0] opcode_r;
    reg [7:0] byte1_r;
    reg [7:0] byte2_r;
    reg [1:0] idx_r;
    reg [15:0] ea_r;
    reg taken_r;
    reg test_bit_r;
    reg irq_meta_r;
    reg irq_sync_r;
    // Decode results held in flops so they stand until the next CALC
    reg [2:0] group_r;
    reg [3:0] mode_r;
    reg [1:0] len_r;
    reg wb_r;
    reg reg_use_r;

    function [3:0] mode_of;
        input [7:0] op;
        begin
            case (op[7:4])
                `ROW_BTB: mode_of = `AM_BTB;
                `ROW_BSC: mode_of = `AM_BSC;
                `ROW_BRA: mode_of = `AM_REL;
                `ROW_RMW_DIR: mode_of = `AM_DIR;
                `ROW_RMW_A: mode_of = `AM_INH;
                `ROW_RMW_X: mode_of = `AM_INH;
                `ROW_RMW_IX1: mode_of = `AM_IX1;
                `ROW_RMW_IX: mode_of = `AM_IX;
                `ROW_CTL_0: mode_of = `AM_INH;
                `ROW_CTL_1: mode_of = `AM_INH;
                `ROW_IMM: begin
                    if (op[3:0] == `LO_BRANCH_SUB)
                        mode_of = `AM_REL;
                    else
                        mode_of = `AM_IMM;
                end
                `ROW_DIR: mode_of = `AM_DIR;
                `ROW_EXT: mode_of = `AM_EXT;
                `ROW_IX2: mode_of = `AM_IX2;
                `ROW_IX1: mode_of = `AM_IX1;
                default: mode_of = `AM_IX;
            endcase
        end
    endfunction

    // Length follows from mode alone
    function [1:0] len_of;
        input [3:0] mode;
        begin
            case (mode)
                `AM_EXT: len_of = `LEN_3;
                `AM_IX2: len_of = `LEN_3;
                `AM_BTB: len_of = `LEN_3;
                `AM_IX: len_of = `LEN_1;
                `AM_INH: len_of = `LEN_1;
                `AM_REL: len_of = `LEN_2;
                `AM_BSC: len_of = `LEN_2;
                default: len_of = `LEN_2;
            endcase
        end
    endfunction

    function [2:0] group_of;
        input [7:0] op;
        begin
            case (op[7:4])
                `ROW_BTB: group_of = `GRP_BITMAN;
                `ROW_BSC: group_of = `GRP_BITMAN;
                `ROW_BRA: group_of = `GRP_BRANCH;
                `ROW_RMW_DIR: group_of = `GRP_RMW;
                `ROW_RMW_A: group_of = `GRP_RMW;
                `ROW_RMW_X: group_of = `GRP_RMW;
                `ROW_RMW_IX1: group_of = `GRP_RMW;
                `ROW_RMW_IX: group_of = `GRP_RMW;
                `ROW_CTL_0: group_of = `GRP_CONTROL;
                `ROW_CTL_1: group_of = `GRP_CONTROL;
                `ROW_IMM: begin
                    if (op[3:0] == `LO_BRANCH_SUB)
                        group_of = `GRP_BRANCH;
                    else
                        group_of = `GRP_REGMEM;
                end
                default: group_of = `GRP_REGMEM;
            endcase
        end
    endfunction

    // Branch conditions, including mask bit and interrupt pin level
    function cond_of;
        input [3:0] cc;
        input c;
        input z;
        input n;
        input h;
        input i;
        input irq;
        begin
            case (cc)
                `BC_ALWAYS: cond_of = 1'b1;
                `BC_NEVER: cond_of = 1'b0;
                `BC_HI: cond_of = ~(c | z);
                `BC_LS: cond_of = c | z;
                `BC_CC: cond_of = ~c;
                `BC_CS: cond_of = c;
                `BC_NE: cond_of = ~z;
                `BC_EQ: cond_of = z;
                `BC_HCC: cond_of = ~h;
                `BC_HCS: cond_of = h;
                `BC_PL: cond_of = ~n;
                `BC_MI: cond_of = n;
                `BC_MASK_CLR: cond_of = ~i;
                `BC_MASK_SET: cond_of = i;
                `BC_IRQ_LOW: cond_of = ~irq;
                `BC_IRQ_HIGH: cond_of = irq;
                default: cond_of = 1'b0;
            endcase
        end
    endfunction

    wire [3:0] cur_mode = mode_of(opcode_r);
    wire [1:0] cur_len = len_of(cur_mode);
    wire [2:0] cur_group = group_of(opcode_r);
    wire [3:0] lo_nib = opcode_r[3:0];

    // Test leaves its operand alone; bit set/clear must read first
    wire wb_now = ((cur_group == `GRP_RMW) &&
                   (lo_nib != `LO_TEST_NZ)) ||
                  (cur_mode == `AM_BSC);

    // Jumps take only an address, no register operand
    wire reg_use_now = (cur_group == `GRP_REGMEM) &&
                       (lo_nib != `LO_JUMP_UNCOND) &&
                       (lo_nib != `LO_JUMP_SUB);

    // Displacement is always the last instruction byte
    wire [7:0] disp = (cur_mode == `AM_BTB) ? byte2_r : byte1_r;
    wire [15:0] disp_ext = {{8{disp[7]}}, disp};
    wire [15:0] target = pc_r + disp_ext;

    // Nine-bit sum so the 8-bit offset form reaches past 255
    wire [8:0] ix1_sum = {1'b0, index_reg} + {1'b0, byte1_r};
    wire [15:0] ix2_sum = {byte1_r, byte2_r} + {8'h00, index_reg};

    reg [15:0] ea_calc;
    always @* begin
        case (cur_mode)
            `AM_IMM: ea_calc = pc_r - {14'h0000, `LEN_1};
            `AM_DIR: ea_calc = {`ZERO_PAGE, byte1_r};
            `AM_EXT: ea_calc = {byte1_r, byte2_r};
            `AM_REL: ea_calc = target;
            `AM_IX: ea_calc = {`ZERO_PAGE, index_reg};
            `AM_IX1: ea_calc = {7'h00, ix1_sum};
            `AM_IX2: ea_calc = ix2_sum;
            `AM_BSC: ea_calc = {`ZERO_PAGE, byte1_r};
            `AM_BTB: ea_calc = target;
            default: ea_calc = pc_r;
        endcase
    end

    reg cond_now;
    always @* begin
        case (cur_mode)
            `AM_REL: begin
                if (opcode_r[7:4] == `ROW_IMM)
                    cond_now = 1'b1;
                else
                    cond_now = cond_of(lo_nib, flag_c, flag_z, flag_n,
                                       flag_h, flag_i, irq_sync_r);
            end
            // Even opcodes branch on set, odd on clear
            `AM_BTB: cond_now = test_bit_r ^ opcode_r[0];
            default: cond_now = 1'b0;
        endcase
    end

    // Pin level only reaches the condition logic via second flop
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_meta_r <= 1'b0;
            irq_sync_r <= 1'b0;
        end else begin
            irq_meta_r <= irq_line;
            irq_sync_r <= irq_meta_r;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `ST_FETCH;
            pc_r <= `PC_RESET;
            opcode_r <= 8'h00;
            byte1_r <= 8'h00;
            byte2_r <= 8'h00;
            idx_r <= 2'h0;
            ea_r <= 16'h0000;
            taken_r <= 1'b0;
            test_bit_r <= 1'b0;
            group_r <= `GRP_REGMEM;
            mode_r <= `AM_IMM;
            len_r <= 2'h0;
            wb_r <= 1'b0;
            reg_use_r <= 1'b0;
        end else begin
            case (state_r)
                `ST_FETCH: state_r <= `ST_CAPT;
                `ST_CAPT: begin
                    // Bytes come from consecutive addresses
                    pc_r <= pc_r + 16'h0001;
                    idx_r <= idx_r + 2'h1;
                    if (idx_r == 2'h0) begin
                        opcode_r <= mem_rdata;
                        taken_r <= 1'b0;
                        if (len_of(mode_of(mem_rdata)) == `LEN_1)
                            state_r <= `ST_CALC;
                        else
                            state_r <= `ST_FETCH;
                    end else if (idx_r == 2'h1) begin
                        byte1_r <= mem_rdata;
                        if (cur_len == `LEN_2)
                            state_r <= `ST_CALC;
                        else
                            state_r <= `ST_FETCH;
                    end else begin
                        byte2_r <= mem_rdata;
                        if (cur_mode == `AM_BTB)
                            state_r <= `ST_TREAD;
                        else
                            state_r <= `ST_CALC;
                    end
                end
                `ST_TREAD: state_r <= `ST_TCAPT;
                `ST_TCAPT: begin
                    test_bit_r <= mem_rdata[opcode_r[3:1]];
                    state_r <= `ST_CALC;
                end
                `ST_CALC: begin
                    // PC already points past the whole instruction
                    ea_r <= ea_calc;
                    taken_r <= cond_now;
                    group_r <= cur_group;
                    mode_r <= cur_mode;
                    len_r <= cur_len;
                    wb_r <= wb_now;
                    reg_use_r <= reg_use_now;
                    if (cond_now)
                        pc_r <= target;
                    state_r <= `ST_DONE;
                end
                `ST_DONE: begin
                    idx_r <= 2'h0;
                    if (pc_load)
                        pc_r <= pc_load_value;
                    state_r <= `ST_FETCH;
                end
                default: state_r <= `ST_FETCH;
            endcase
        end
    end

    assign mem_rd = (state_r == `ST_FETCH) || (state_r == `ST_TREAD);
    assign mem_addr = (state_r == `ST_TREAD) ? {`ZERO_PAGE, byte1_r} : pc_r;

    assign instr_valid = (state_r == `ST_DONE);
    assign opcode = opcode_r;
    assign instr_group = group_r;
    assign addr_mode = mode_r;
    assign instr_len = len_r;
    assign eff_addr = ea_r;
    assign operand = byte1_r;
    assign bit_num = opcode_r[3:1];
    assign branch_taken = taken_r;
    assign bit_carry = test_bit_r;
    assign pc = pc_r;
    assign write_back = wb_r;
    assign uses_register = reg_use_r;

endmodule // cpu_opcode_addressing_unit

// ===== design/opcode_addr_map.vh
`ifndef OPCODE_ADDR_MAP_VH
`define OPCODE_ADDR_MAP_VH

// Sequencer states
`define ST_FETCH 3'h0
`define ST_CAPT 3'h1
`define ST_TREAD 3'h2
`define ST_TCAPT 3'h3
`define ST_CALC 3'h4
`define ST_DONE 3'h5

// Instruction groups
`define GRP_REGMEM 3'h0
`define GRP_RMW 3'h1
`define GRP_BRANCH 3'h2
`define GRP_BITMAN 3'h3
`define GRP_CONTROL 3'h4

// Addressing modes
`define AM_IMM 4'h0
`define AM_DIR 4'h1
`define AM_EXT 4'h2
`define AM_REL 4'h3
`define AM_IX 4'h4
`define AM_IX1 4'h5
`define AM_IX2 4'h6
`define AM_BSC 4'h7
`define AM_BTB 4'h8
`define AM_INH 4'h9

// Opcode rows (high nibble)
`define ROW_BTB 4'h0
`define ROW_BSC 4'h1
`define ROW_BRA 4'h2
`define ROW_RMW_DIR 4'h3
`define ROW_RMW_A 4'h4
`define ROW_RMW_X 4'h5
`define ROW_RMW_IX1 4'h6
`define ROW_RMW_IX 4'h7
`define ROW_CTL_0 4'h8
`define ROW_CTL_1 4'h9
`define ROW_IMM 4'ha
`define ROW_DIR 4'hb
`define ROW_EXT 4'hc
`define ROW_IX2 4'hd
`define ROW_IX1 4'he
`define ROW_IX 4'hf

// Low-nibble codes with special meaning
`define LO_TEST_NZ 4'hd
`define LO_JUMP_UNCOND 4'hc
`define LO_JUMP_SUB 4'hd
`define LO_BRANCH_SUB 4'hd

// Branch condition codes (low nibble of branch row)
`define BC_ALWAYS 4'h0
`define BC_NEVER 4'h1
`define BC_HI 4'h2
`define BC_LS 4'h3
`define BC_CC 4'h4
`define BC_CS 4'h5
`define BC_NE 4'h6
`define BC_EQ 4'h7
`define BC_HCC 4'h8
`define BC_HCS 4'h9
`define BC_PL 4'ha
`define BC_MI 4'hb
`define BC_MASK_CLR 4'hc
`define BC_MASK_SET 4'hd
`define BC_IRQ_LOW 4'he
`define BC_IRQ_HIGH 4'hf

// Instruction lengths in bytes
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

`define PC_RESET 16'h0000
`define ZERO_PAGE 8'h00

`endif

// ===== sim/cpu_opcode_addressing_unit_chk.sv
module cpu_opcode_addressing_unit_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire [15:0] mem_addr,
    input wire mem_rd,
    input wire [7:0] index_reg,
    input wire instr_valid,
    input wire [2:0] instr_group,
    input wire [3:0] addr_mode,
    input wire [1:0] instr_len,
    input wire [15:0] eff_addr,
    input wire [7:0] operand,
    input wire branch_taken,
    input wire [15:0] pc
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_one_read;
        mem_rd ##1 !mem_rd;
    endsequence
    sequence s_done;
        instr_valid ##1 !instr_valid;
    endsequence

    AST_RD_SPACING: assert property (mem_rd |-> s_one_read)
        else $error("memory reads back to back");
    AST_VALID_PULSE: assert property (instr_valid |-> s_done)
        else $error("decode strobe longer than one cycle");
    AST_BRANCH_LEN: assert property (instr_valid && instr_group == 3'h2
        |-> instr_len == 2'h2)
        else $error("branch length not two");
    AST_INH_LEN: assert property (instr_valid && (addr_mode == 4'h9
        || addr_mode == 4'h4) |-> instr_len == 2'h1)
        else $error("one-byte form has wrong length");
    AST_LONG_LEN: assert property (instr_valid && (addr_mode == 4'h2
        || addr_mode == 4'h6 || addr_mode == 4'h8) |-> instr_len == 2'h3)
        else $error("three-byte form has wrong length");
    AST_DIR_EA: assert property (instr_valid && (addr_mode == 4'h1
        || addr_mode == 4'h7) |-> eff_addr == {8'h00, operand})
        else $error("direct address not zero-extended");
    AST_IX_EA: assert property (instr_valid && addr_mode == 4'h4
        |-> eff_addr == {8'h00, $past(index_reg)})
        else $error("indexed address wrong");
    AST_IX1_EA: assert property (instr_valid && addr_mode == 4'h5
        |-> eff_addr == {8'h00, operand} + {8'h00, $past(index_reg)})
        else $error("indexed offset sum wrong");
    AST_PC_NEXT: assert property (instr_valid && !branch_taken
        && addr_mode != 4'h8 |-> pc == $past(mem_addr, 3) + 16'h1)
        else $error("pc not past last byte");
    AST_BTB_READ: assert property (instr_valid && addr_mode == 4'h8
        |-> $past(mem_rd, 3) && $past(mem_addr, 3) == {8'h00, operand})
        else $error("bit test read address wrong");
endmodule // cpu_opcode_addressing_unit_chk

bind cpu_opcode_addressing_unit cpu_opcode_addressing_unit_chk u_chk (.*);

// ===== sim/prog_data_mem.sv
module prog_data_mem (
    input wire clk_sys,
    input wire mem_rd,
    input wire [15:0] mem_addr,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // All cells read/write: no write-only location meets a read-back
    logic [7:0] mem [0:255];

    initial mem_rdata = 8'h00;
    // Data valid the cycle after the strobe; between reads the line churns
    always @(posedge clk_sys) begin
        if (mem_rd) begin
            mem_rdata <= mem[mem_addr[7:0]];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // prog_data_mem

// ===== sim/tb_cpu_opcode_addressing_unit.sv
module tb_cpu_opcode_addressing_unit;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [7:0] at;
        logic [23:0] b;
        logic [1:0] len;
        logic [2:0] grp;
        logic [3:0] mode;
        logic [15:0] ea;
        logic [4:0] ctl; // irq, mask, taken, write-back, register
        logic [15:0] pc;
    } row_t;
    row_t rows [19];
    logic clk_sys = 1'b0, rst_n = 1'b0, flag_i = 1'b0, irq_line = 1'b0;
    logic pc_load = 1'b0;
    logic [15:0] pc_load_value = 16'h0000;
    logic [7:0] index_reg = 8'hff;
    wire [15:0] mem_addr, eff_addr, pc;
    wire [7:0] mem_rdata, opcode, operand;
    wire [3:0] addr_mode;
    wire [2:0] instr_group, bit_num;
    wire [1:0] instr_len;
    wire mem_rd, instr_valid, branch_taken, bit_carry, write_back;
    wire uses_register;
    int n_fail = 0, comparisons = 0, cyc = 0, i, k;

    always #25 clk_sys = ~clk_sys;

    prog_data_mem u_prog_data_mem (.clk_sys(clk_sys), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata));

    cpu_opcode_addressing_unit u_cpu_opcode_addressing_unit (
        .clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .index_reg(index_reg),
        .flag_c(1'b0), .flag_z(1'b0), .flag_n(1'b0), .flag_h(1'b0),
        .flag_i(flag_i), .irq_line(irq_line), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .instr_valid(instr_valid),
        .opcode(opcode), .instr_group(instr_group), .addr_mode(addr_mode),
        .instr_len(instr_len), .eff_addr(eff_addr), .operand(operand),
        .bit_num(bit_num), .branch_taken(branch_taken),
        .bit_carry(bit_carry), .write_back(write_back),
        .uses_register(uses_register), .pc(pc));

    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Bounded wait; entered while the previous strobe may still be high
    task automatic wait_valid();
        for (k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            if (instr_valid === 1'b1) break;
        end
        chk("instr_valid", 16'h1, {15'h0, instr_valid});
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        rows = '{
            '{8'h00, 24'ha65500, 2'h2, 3'h0, 4'h0, 16'h0001, 5'h01, 16'h0002},
            '{8'h02, 24'hb74000, 2'h2, 3'h0, 4'h1, 16'h0040, 5'h01, 16'h0004},
            '{8'h04, 24'hc61234, 2'h3, 3'h0, 4'h2, 16'h1234, 5'h01, 16'h0007},
            '{8'h07, 24'hebff00, 2'h2, 3'h0, 4'h5, 16'h01fe, 5'h01, 16'h0009},
            '{8'h09, 24'hf60000, 2'h1, 3'h0, 4'h4, 16'h00ff, 5'h01, 16'h000a},
            '{8'h0a, 24'hd61000, 2'h3, 3'h0, 4'h6, 16'h10ff, 5'h01, 16'h000d},
            '{8'h0d, 24'h3c4000, 2'h2, 3'h1, 4'h1, 16'h0040, 5'h02, 16'h000f},
            '{8'h0f, 24'h3d4000, 2'h2, 3'h1, 4'h1, 16'h0040, 5'h00, 16'h0011},
            '{8'h11, 24'h4c0000, 2'h1, 3'h1, 4'h9, 16'h0000, 5'h02, 16'h0012},
            '{8'h12, 24'h144000, 2'h2, 3'h3, 4'h7, 16'h0040, 5'h02, 16'h0014},
            '{8'h14, 24'h202000, 2'h2, 3'h2, 4'h3, 16'h0036, 5'h04, 16'h0036},
            '{8'h36, 24'h211000, 2'h2, 3'h2, 4'h3, 16'h0048, 5'h00, 16'h0038},
            '{8'h38, 24'h2cf000, 2'h2, 3'h2, 4'h3, 16'h002a, 5'h04, 16'h002a},
            '{8'h2a, 24'h2d0500, 2'h2, 3'h2, 4'h3, 16'h0031, 5'h00, 16'h002c},
            '{8'h2c, 24'h2f1000, 2'h2, 3'h2, 4'h3, 16'h003e, 5'h14, 16'h003e},
            '{8'h3e, 24'h2e0500, 2'h2, 3'h2, 4'h3, 16'h0045, 5'h10, 16'h0040},
            '{8'h40, 24'h008003, 2'h3, 3'h3, 4'h8, 16'h0046, 5'h04, 16'h0046},
            '{8'h46, 24'h038005, 2'h3, 3'h3, 4'h8, 16'h004e, 5'h04, 16'h004e},
            '{8'h4e, 24'hcc0060, 2'h3, 3'h0, 4'h2, 16'h0060, 5'h00, 16'h0051}};
        foreach (rows[r]) begin
            for (k = 0; k < rows[r].len; k++) begin
                u_prog_data_mem.mem[rows[r].at + k] = rows[r].b[23 - 8 * k -: 8];
            end
        end
        u_prog_data_mem.mem[8'h80] = 8'h01;
        u_prog_data_mem.mem[8'h60] = 8'h9d;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        for (i = 0; i < 19; i++) begin
            irq_line = rows[i].ctl[4];
            flag_i = rows[i].ctl[3];
            wait_valid();
            chk("opcode", {8'h00, rows[i].b[23:16]}, {8'h00, opcode});
            chk("group", {13'h0, rows[i].grp}, {13'h0, instr_group});
            chk("mode", {12'h0, rows[i].mode}, {12'h0, addr_mode});
            chk("length", {14'h0, rows[i].len}, {14'h0, instr_len});
            chk("pc", rows[i].pc, pc);
            chk("taken", {15'h0, rows[i].ctl[2]}, {15'h0, branch_taken});
            chk("write_back", {15'h0, rows[i].ctl[1]}, {15'h0, write_back});
            if (rows[i].mode != 4'h9 && rows[i].ea != 16'h0000)
                chk("eff_addr", rows[i].ea, eff_addr);
            if (rows[i].grp == 3'h0)
                chk("uses_reg", {15'h0, rows[i].ctl[0]}, {15'h0, uses_register});
            if (rows[i].grp == 3'h3)
                chk("bit_num", {13'h0, rows[i].b[19:17]}, {13'h0, bit_num});
            if (rows[i].mode == 4'h8)
                chk("carry", {15'h0, rows[i].ctl[2] ^ rows[i].b[16]}, {15'h0, bit_carry});
        end
        // Jump takes its target through the load port in the strobe cycle
        pc_load_value = 16'h0060;
        pc_load = 1'b1;
        @(negedge clk_sys);
        pc_load = 1'b0;
        wait_valid();
        chk("opcode", 16'h009d, {8'h00, opcode});
        chk("group", 16'h0004, {13'h0, instr_group});
        chk("pc", 16'h0061, pc);
        // Reset during the next opcode fetch restarts fetching from zero
        @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        chk("mem_addr", 16'h0000, mem_addr);
        chk("pc", 16'h0000, pc);
        rst_n = 1'b1;
        wait_valid();
        chk("opcode", 16'h00a6, {8'h00, opcode});
        chk("operand", 16'h0055, {8'h00, operand});
        give_verdict();
    end
endmodule // tb_cpu_opcode_addressing_unit
